// ===== i2csf_pkg.sv
`default_nettype none
package i2csf_pkg;

   // status register bit positions
   localparam int unsigned STAT_DONE_BIT  = 7;
   localparam int unsigned STAT_SLAVE_BIT = 6;
   localparam int unsigned STAT_BUSY_BIT  = 5;
   localparam int unsigned STAT_ARB_BIT   = 4;
   localparam int unsigned STAT_UNUSED    = 3;
   localparam int unsigned STAT_DIR_BIT   = 2;
   localparam int unsigned STAT_IRQ_BIT   = 1;
   localparam int unsigned STAT_ACK_BIT   = 0;

   // values after reset
   localparam logic [7:0] STAT_RESET  = 8'h00;
   localparam logic [7:0] SHIFT_RESET = 8'h00;
   localparam logic [3:0] CNT_RESET   = 4'h0;
   localparam logic       ACK_RESET   = 1'h0;

   // bit slot that carries the acknowledge
   localparam logic [3:0] ACK_SLOT = 4'h8;

   // cpu side strobes towards the block
   typedef struct packed {
      logic       stat_wr;
      logic [7:0] wdata;
      logic       data_rd;
      logic       data_wr;
      logic       ctrl_wr;
   } i2csf_cpu_t;

   // one sample of the two bus lines
   typedef struct packed {
      logic scl;
      logic sda;
   } i2csf_line_t;

   localparam i2csf_line_t LINE_IDLE = 2'h3;

   // bus monitor states, gray along idle-addr-data
   typedef enum logic [1:0] {
      MON_IDLE = 2'b00,
      MON_ADDR = 2'b01,
      MON_DATA = 2'b11
   } i2csf_mon_t;

endpackage
`default_nettype wire

// ===== i2csf_status.sv
// Notes on behaviour
// - bit 7 sets when a byte this module takes part in ends; the start of the next byte does not clear it.
// - bit 7 clears on data read in receive or data write in transmit.
// - bit 6 sets when the calling address equals the programmed address.
// - a control register write clears bit 6 unless an address match comes in the same cycle.
// - bit 5 rises on START and falls on STOP, master or slave.
// - bit 4 sets on arbitration loss, stays until software writes one.
// - when addressed, bit 2 holds the calling read/write bit.
// - bit 1 sets on byte done, address match or arbitration loss.
// - bit 1 clears only when software writes one to it.
// - bit 0 shows the acknowledge sampled after each byte that sets bit 7; 1 means none.
`timescale 1ns/100ps
`default_nettype none
module i2csf_status (
   // clock and reset
   input  wire logic                    clk,
   input  wire logic                    rst_b,
   // cpu register access
   input  wire i2csf_pkg::i2csf_cpu_t   cpu,
   output logic [7:0]                   stat_rdata,
   // module configuration and events
   input  wire logic                    tx_mode,
   input  wire logic                    master_mode,
   input  wire logic [6:0]              slave_addr,
   input  wire logic                    arb_lost_evt,
   // bus pins, asynchronous
   input  wire i2csf_pkg::i2csf_line_t  bus_in
);

   // does the received byte call this module
   function automatic logic addr_hit(input logic [7:0] b,
                                     input logic [6:0] a);
      addr_hit = (b[7:1] == a);
   endfunction

   // pin synchroniser and condition detect
   i2csf_pkg::i2csf_line_t sync1_r;
   i2csf_pkg::i2csf_line_t sync2_r;
   i2csf_pkg::i2csf_line_t prev_r;
   i2csf_pkg::i2csf_line_t sync1_nxt;
   i2csf_pkg::i2csf_line_t sync2_nxt;
   i2csf_pkg::i2csf_line_t prev_nxt;

   always_comb begin
      sync1_nxt = bus_in;
      sync2_nxt = sync1_r;
      prev_nxt  = sync2_r;
   end

   // idle high so no false START comes out of reset
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         sync1_r <= i2csf_pkg::LINE_IDLE;
         sync2_r <= i2csf_pkg::LINE_IDLE;
         prev_r  <= i2csf_pkg::LINE_IDLE;
      end else begin
         sync1_r <= sync1_nxt;
         sync2_r <= sync2_nxt;
         prev_r  <= prev_nxt;
      end
   end

   logic scl_rise;
   logic scl_steady;
   logic start_det;
   logic stop_det;

   always_comb begin
      scl_rise   = sync2_r.scl & ~prev_r.scl;
      scl_steady = sync2_r.scl & prev_r.scl;
      start_det  = scl_steady & prev_r.sda & ~sync2_r.sda;
      stop_det   = scl_steady & ~prev_r.sda & sync2_r.sda;
   end

   // bus monitor: bit count, shifter, byte events
   i2csf_pkg::i2csf_mon_t mon_r;
   i2csf_pkg::i2csf_mon_t mon_nxt;
   logic [3:0]            cnt_r;
   logic [3:0]            cnt_nxt;
   logic [7:0]            shift_r;
   logic [7:0]            shift_nxt;
   logic                  sel_r;
   logic                  sel_nxt;
   logic                  ack_evt;
   logic                  match_evt;
   logic                  done_evt;

   always_comb begin
      mon_nxt   = mon_r;
      cnt_nxt   = cnt_r;
      shift_nxt = shift_r;
      sel_nxt   = sel_r;
      ack_evt   = 1'b0;
      match_evt = 1'b0;
      // repeated START restarts the address phase
      if (start_det) begin
         mon_nxt = i2csf_pkg::MON_ADDR;
         cnt_nxt = i2csf_pkg::CNT_RESET;
         sel_nxt = 1'b0;
      end else if (stop_det) begin
         mon_nxt = i2csf_pkg::MON_IDLE;
         cnt_nxt = i2csf_pkg::CNT_RESET;
         sel_nxt = 1'b0;
      end else if (scl_rise && mon_r != i2csf_pkg::MON_IDLE) begin
         if (cnt_r == i2csf_pkg::ACK_SLOT) begin
            ack_evt = 1'b1;
            cnt_nxt = i2csf_pkg::CNT_RESET;
            mon_nxt = i2csf_pkg::MON_DATA;
            if (mon_r == i2csf_pkg::MON_ADDR &&
                addr_hit(shift_r, slave_addr)) begin
               match_evt = 1'b1;
               sel_nxt   = 1'b1;
            end
         end else begin
            shift_nxt = {shift_r[6:0], sync2_r.sda};
            cnt_nxt   = cnt_r + 4'h1;
         end
      end
      // only bytes this module takes part in count as transfers
      done_evt = ack_evt & (master_mode | sel_r | match_evt);
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         mon_r   <= i2csf_pkg::MON_IDLE;
         cnt_r   <= i2csf_pkg::CNT_RESET;
         shift_r <= i2csf_pkg::SHIFT_RESET;
         sel_r   <= 1'b0;
      end else begin
         mon_r   <= mon_nxt;
         cnt_r   <= cnt_nxt;
         shift_r <= shift_nxt;
         sel_r   <= sel_nxt;
      end
   end

   // status flags; a setting event always wins over a clear
   logic done_r,  done_nxt;
   logic slave_r, slave_nxt;
   logic busy_r,  busy_nxt;
   logic arb_r,   arb_nxt;
   logic dir_r,   dir_nxt;
   logic irq_r,   irq_nxt;
   logic ack_r,   ack_nxt;
   logic done_clr;
   logic arb_clr;
   logic irq_clr;

   always_comb begin
      done_clr = (cpu.data_rd & ~tx_mode) | (cpu.data_wr & tx_mode);
      arb_clr  = cpu.stat_wr & cpu.wdata[i2csf_pkg::STAT_ARB_BIT];
      irq_clr  = cpu.stat_wr & cpu.wdata[i2csf_pkg::STAT_IRQ_BIT];

      done_nxt = done_evt ? 1'b1 : (done_clr ? 1'b0 : done_r);
      slave_nxt = match_evt ? 1'b1 : (cpu.ctrl_wr ? 1'b0 : slave_r);
      busy_nxt = start_det ? 1'b1 : (stop_det ? 1'b0 : busy_r);
      arb_nxt = arb_lost_evt ? 1'b1 : (arb_clr ? 1'b0 : arb_r);
      dir_nxt = match_evt ? shift_r[0] : dir_r;
      irq_nxt = (done_evt | match_evt | arb_lost_evt) ? 1'b1 :
                (irq_clr ? 1'b0 : irq_r);
      ack_nxt = done_evt ? sync2_r.sda : ack_r;
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         done_r  <= i2csf_pkg::STAT_RESET[i2csf_pkg::STAT_DONE_BIT];
         slave_r <= i2csf_pkg::STAT_RESET[i2csf_pkg::STAT_SLAVE_BIT];
         busy_r  <= i2csf_pkg::STAT_RESET[i2csf_pkg::STAT_BUSY_BIT];
         arb_r   <= i2csf_pkg::STAT_RESET[i2csf_pkg::STAT_ARB_BIT];
         dir_r   <= i2csf_pkg::STAT_RESET[i2csf_pkg::STAT_DIR_BIT];
         irq_r   <= i2csf_pkg::STAT_RESET[i2csf_pkg::STAT_IRQ_BIT];
         ack_r   <= i2csf_pkg::ACK_RESET;
      end else begin
         done_r  <= done_nxt;
         slave_r <= slave_nxt;
         busy_r  <= busy_nxt;
         arb_r   <= arb_nxt;
         dir_r   <= dir_nxt;
         irq_r   <= irq_nxt;
         ack_r   <= ack_nxt;
      end
   end

   always_comb begin
      stat_rdata = i2csf_pkg::STAT_RESET;
      stat_rdata[i2csf_pkg::STAT_DONE_BIT]  = done_r;
      stat_rdata[i2csf_pkg::STAT_SLAVE_BIT] = slave_r;
      stat_rdata[i2csf_pkg::STAT_BUSY_BIT]  = busy_r;
      stat_rdata[i2csf_pkg::STAT_ARB_BIT]   = arb_r;
      stat_rdata[i2csf_pkg::STAT_UNUSED]    = 1'b0;
      stat_rdata[i2csf_pkg::STAT_DIR_BIT]   = dir_r;
      stat_rdata[i2csf_pkg::STAT_IRQ_BIT]   = irq_r;
      stat_rdata[i2csf_pkg::STAT_ACK_BIT]   = ack_r;
   end

   // checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   a_done_set : assert property (
      done_evt |=> stat_rdata[7])
      else $error("done flag not set after byte");

   a_done_clr : assert property (
      (cpu.data_rd && !tx_mode && !done_evt) |=> !stat_rdata[7])
      else $error("done flag not cleared by data read");

   a_slave_set : assert property (
      (mon_r == i2csf_pkg::MON_ADDR && scl_rise && !start_det &&
       !stop_det && cnt_r == i2csf_pkg::ACK_SLOT && shift_r[7:1] == slave_addr)
      |=> stat_rdata[6] && stat_rdata[1])
      else $error("address match not flagged");

   a_slave_clr : assert property (
      (cpu.ctrl_wr && !match_evt) |=> !stat_rdata[6])
      else $error("control write did not clear slave flag");

   a_busy_edge : assert property (
      (scl_steady && prev_r.sda && !sync2_r.sda) |=>
      stat_rdata[5] && mon_r == i2csf_pkg::MON_ADDR)
      else $error("START not tracked");

   a_busy_stop : assert property (
      stop_det |=> !stat_rdata[5])
      else $error("STOP did not clear busy");

   a_arb_hold : assert property (
      (stat_rdata[4] && !(cpu.stat_wr && cpu.wdata[4])) |=>
      stat_rdata[4])
      else $error("arbitration flag dropped without write");

   a_dir_take : assert property (
      match_evt |=> stat_rdata[2] == $past(shift_r[0]))
      else $error("direction bit not captured");

   a_irq_hold : assert property (
      (stat_rdata[1] && !(cpu.stat_wr && cpu.wdata[1])) |=>
      stat_rdata[1])
      else $error("interrupt flag dropped without write");

   a_irq_arb : assert property (
      arb_lost_evt |=> stat_rdata[1] && stat_rdata[4])
      else $error("arbitration loss not pending");

   a_ack_seen : assert property (
      done_evt |=> stat_rdata[0] == $past(sync2_r.sda))
      else $error("acknowledge bit wrong");

   a_bit_three : assert property (
      !stat_rdata[3])
      else $error("unused bit reads one");

   a_done_hold : assert property (
      (stat_rdata[7] && !done_clr) |=> stat_rdata[7])
      else $error("done flag dropped without data access");

   a_done_wr : assert property (
      (cpu.data_wr && tx_mode && !done_evt) |=> !stat_rdata[7])
      else $error("done flag not cleared by data write");

   a_slave_hold : assert property (
      (stat_rdata[6] && !cpu.ctrl_wr) |=> stat_rdata[6])
      else $error("slave flag dropped without control write");

   a_busy_hold : assert property (
      (!start_det && !stop_det) |=> $stable(stat_rdata[5]))
      else $error("busy changed without START or STOP");

   a_dir_hold : assert property (
      !match_evt |=> $stable(stat_rdata[2]))
      else $error("direction bit changed without a call");

   a_irq_done : assert property (
      done_evt |=> stat_rdata[1])
      else $error("byte done not pending");

   a_ack_hold : assert property (
      !done_evt |=> $stable(stat_rdata[0]))
      else $error("acknowledge bit changed between bytes");

   c_slave_read : cover property (
      match_evt && shift_r[0]);
   c_arb_lost : cover property (
      arb_lost_evt ##[1:50] (cpu.stat_wr && cpu.wdata[4]));
   c_frame : cover property (
      start_det ##[1:1000] done_evt ##[1:1000] stop_det);
   c_no_ack : cover property (
      done_evt && sync2_r.sda);
   c_master_byte : cover property (
      done_evt && master_mode);

endmodule
`default_nettype wire

// ===== i2csf_bus_model.sv
`timescale 1ns/100ps
`default_nettype none
module i2csf_bus_model (
   // both lines, released means pulled high
   output var i2csf_pkg::i2csf_line_t line
);
   initial line = i2csf_pkg::LINE_IDLE;

   // clock stands high between frames
   // nba so a change on a clock edge is seen only after that edge
   task automatic start();
      #7 line.sda <= 1'b1;
      #43 line.scl <= 1'b1;
      #50 line.sda <= 1'b0;
      #100 line.scl <= 1'b0;
      #50;
   endtask

   task automatic send_bit(input logic b);
      line.sda <= b;
      #50 line.scl <= 1'b1;
      #100 line.scl <= 1'b0;
      #50;
   endtask

   // msb first, then the receiver's ack slot
   task automatic send_byte(input logic [7:0] d, input logic nak);
      for (int i = 7; i >= 0; i--) begin
         send_bit(d[i]);
      end
      send_bit(nak);
   endtask

   task automatic stop();
      line.sda <= 1'b0;
      #50 line.scl <= 1'b1;
      #50 line.sda <= 1'b1;
      #100;
   endtask
endmodule
`default_nettype wire

// ===== tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
   logic                   clk;
   logic                   rst_b;
   i2csf_pkg::i2csf_cpu_t  cpu;
   logic [7:0]             stat_rdata;
   logic                   tx_mode;
   logic                   master_mode;
   logic [6:0]             slave_addr;
   logic                   arb_lost_evt;
   i2csf_pkg::i2csf_line_t bus_line;
   int                     miscompares;
   int                     checks_done;
   logic [6:0]             a;
   logic                   rw;

   i2csf_status i_dut (
      .clk(clk), .rst_b(rst_b), .cpu(cpu), .stat_rdata(stat_rdata),
      .tx_mode(tx_mode), .master_mode(master_mode), .slave_addr(slave_addr),
      .arb_lost_evt(arb_lost_evt), .bus_in(bus_line)
   );
   i2csf_bus_model i_bus (.line(bus_line));

   initial clk = 1'b0;
   always #12.5 clk = ~clk;

   // flags after an own byte's ack slot
   function automatic logic [7:0] byte_flags(input logic slv, input logic d, input logic nak);
      return (8'h01 << i2csf_pkg::STAT_BUSY_BIT) | (8'h01 << i2csf_pkg::STAT_DONE_BIT)
         | (8'h01 << i2csf_pkg::STAT_IRQ_BIT) | ({7'h00, slv} << i2csf_pkg::STAT_SLAVE_BIT)
         | ({7'h00, d} << i2csf_pkg::STAT_DIR_BIT) | {7'h00, nak};
   endfunction

   // waits past the pin synchroniser before sampling
   task automatic expect_bits(input string name, input logic [7:0] mask, input logic [7:0] exp);
      repeat (3) @(posedge clk);
      #1;
      checks_done++;
      if ((stat_rdata & mask) !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", name, exp, stat_rdata & mask);
      end
   endtask

   task automatic cpu_op(input i2csf_pkg::i2csf_cpu_t c);
      @(posedge clk) cpu <= c;
      @(posedge clk) cpu <= '0;
   endtask

   task automatic tally_and_finish();
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   initial begin
      #200000;
      miscompares++;
      tally_and_finish();
   end

   initial begin
      rst_b <= 1'b0;
      cpu <= '0;
      tx_mode <= 1'b0;
      master_mode <= 1'b0;
      slave_addr <= 7'h00;
      arb_lost_evt <= 1'b0;
      miscompares = 0;
      checks_done = 0;
      void'($urandom(32'h4aef));
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      expect_bits("reset", 8'hff, i2csf_pkg::STAT_RESET);
      for (int k = 0; k < 2; k++) begin
         a = 7'($urandom);
         rw = k[0];
         @(posedge clk) slave_addr <= a;
         i_bus.start();
         expect_bits("busy", 8'h20, 8'h20);
         i_bus.send_byte({a, rw}, 1'b0);
         expect_bits("addressed", 8'hff, byte_flags(1'b1, rw, 1'b0));
         i_bus.send_byte(8'($urandom), 1'b1);
         expect_bits("nak", 8'h01, 8'h01);
         @(posedge clk) tx_mode <= rw;
         cpu_op('{1'b0, 8'h00, ~rw, rw, 1'b0});
         expect_bits("done clear", 8'h80, 8'h00);
         cpu_op('{1'b0, 8'h00, 1'b0, 1'b0, 1'b1});
         expect_bits("slave clear", 8'h40, 8'h00);
         cpu_op('{1'b1, 8'hfd, 1'b0, 1'b0, 1'b0});
         expect_bits("irq kept", 8'hff, byte_flags(1'b0, rw, 1'b1) & 8'h7f);
         cpu_op('{1'b1, 8'h02, 1'b0, 1'b0, 1'b0});
         expect_bits("irq clear", 8'h02, 8'h00);
         i_bus.stop();
         expect_bits("idle", 8'h20, 8'h00);
      end
      i_bus.start();
      i_bus.send_byte({a ^ 7'h01, 1'b0}, 1'b0);
      expect_bits("foreign", 8'hc2, 8'h00);
      @(posedge clk) master_mode <= 1'b1;
      i_bus.send_byte(8'($urandom), 1'b0);
      expect_bits("master", 8'h83, 8'h82);
      i_bus.stop();
      // irq cleared first so the loss itself must raise it
      cpu_op('{1'b1, 8'h02, 1'b0, 1'b0, 1'b0});
      expect_bits("pre arb", 8'h12, 8'h00);
      @(posedge clk) master_mode <= 1'b0;
      arb_lost_evt <= 1'b1;
      @(posedge clk) arb_lost_evt <= 1'b0;
      expect_bits("arb", 8'h12, 8'h12);
      cpu_op('{1'b1, 8'h02, 1'b0, 1'b0, 1'b0});
      expect_bits("arb kept", 8'h12, 8'h10);
      cpu_op('{1'b1, 8'h10, 1'b0, 1'b0, 1'b0});
      expect_bits("arb clear", 8'h12, 8'h00);
      tally_and_finish();
   end
endmodule
`default_nettype wire
